// ==== hdl/usc_pkg.sv ====
// constants for the serial channel status, clock select and command block
// Functional notes
// - idle flag after last stop, holding empty
// - free flag on transfer or first enable
// - no sending of disabled-time writes; free reads zero
// - queue-full flag when three characters wait
// - waiting flag while fifo not empty
// - decode receiver clock-source field
// - transmitter clock-source field decoded independently
// - several commands per write are executed
// - decode three-bit general command
// - pointer reset targets first mode register
// - receiver reset disables, empties fifo
// - transmitter reset disables, clears idle and free
// - error clear drops break, framing, parity, overrun
// - break-change clear drops break edge flag
// - start break drives line low after characters
// - start break only when enabled, ignores cts
// - stop break returns mark, resumes sending
// - decode two-bit transmitter command
// - enable sets idle and free flags
// - disable clears flags, current character finishes
// - receiver enable searches start bit
// - receiver disable drops partial, ignored in loop/multidrop
package usc_pkg;
  localparam logic [1:0] ADDR_LINE_STATUS  = 2'h0;
  localparam logic [1:0] ADDR_CLOCK_SOURCE = 2'h1;
  localparam logic [1:0] ADDR_COMMAND      = 2'h2;
  localparam logic [1:0] ADDR_TX_DATA      = 2'h3;
  localparam logic [1:0] ADDR_RX_DATA      = 2'h3;
  localparam logic [1:0] ADDR_IRQ_STATUS   = 2'h2;
  localparam logic [1:0] ADDR_MODE         = 2'h1;
  // clock source encodings
  localparam logic [3:0] CS_TIMER = 4'hd;
  localparam logic [3:0] CS_EXT16 = 4'he;
  localparam logic [3:0] CS_EXT1  = 4'hf;
  localparam logic [7:0] CS_RESET = 8'hdd;
  // command field positions
  localparam int RXC_LSB = 0;
  localparam int TXC_LSB = 2;
  localparam int GEN_LSB = 4;
  localparam logic [1:0] DIR_NONE    = 2'h0;
  localparam logic [1:0] DIR_ENABLE  = 2'h1;
  localparam logic [1:0] DIR_DISABLE = 2'h2;
  localparam logic [2:0] GC_NONE      = 3'h0;
  localparam logic [2:0] GC_PTR_RST   = 3'h1;
  localparam logic [2:0] GC_RX_RST    = 3'h2;
  localparam logic [2:0] GC_TX_RST    = 3'h3;
  localparam logic [2:0] GC_ERR_CLR   = 3'h4;
  localparam logic [2:0] GC_BRK_CLR   = 3'h5;
  localparam logic [2:0] GC_BRK_START = 3'h6;
  localparam logic [2:0] GC_BRK_STOP  = 3'h7;
  // line status bit positions
  localparam int ST_RX_WAIT = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_TX_FREE = 2;
  localparam int ST_TX_IDLE = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_PARITY  = 5;
  localparam int ST_FRAMING = 6;
  localparam int ST_BREAK   = 7;
  localparam int IRQ_BRK_EDGE = 2;
  localparam int FIFO_DEPTH   = 3;
  localparam int BAUD_DIV_DEFAULT = 16;
  localparam logic [3:0] CNT16 = 4'hf;
endpackage : usc_pkg

// ==== hdl/usc_top.sv ====
// serial channel status, clock selection and command decoding
`timescale 1ns/1ns
`default_nettype none
module usc_top #(
  parameter int DIV = usc_pkg::BAUD_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // register port
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // serial pins
  input  wire logic       rxd,
  input  wire logic       ext_clk,
  output logic            txd,
  // mode and status side signals
  input  wire logic       loopback_mode,
  input  wire logic       multidrop_mode,
  output logic            mode_ptr_first,
  output logic            rx_enabled,
  output logic            tx_enabled
);
  import usc_pkg::*;

  typedef enum {RX_IDLE, RX_DATA, RX_STOP} usc_rx_type;
  typedef enum {TX_IDLE, TX_SHIFT, TX_BREAK} usc_tx_type;

  function automatic logic tick_of(input logic [3:0] sel, input logic timer_tick, input logic ext_rise,
                                   input logic [3:0] ext16_cnt);
    case (sel)
      CS_TIMER: tick_of = timer_tick;
      CS_EXT16: tick_of = ext_rise && (ext16_cnt == CNT16);
      CS_EXT1:  tick_of = ext_rise;
      default:  tick_of = timer_tick;
    endcase
  endfunction : tick_of

  // pin synchronisers: second and third stage must agree
  logic [2:0] rx_sync_ff, ck_sync_ff;
  logic       rx_line_ff, ck_line_ff, ck_prev_ff;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_sync_ff <= 3'h7;
      ck_sync_ff <= 3'h0;
      rx_line_ff <= 1'b1;
      ck_line_ff <= 1'b0;
      ck_prev_ff <= 1'b0;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], rxd};
      ck_sync_ff <= {ck_sync_ff[1:0], ext_clk};
      if (rx_sync_ff[1] == rx_sync_ff[2]) rx_line_ff <= rx_sync_ff[2];
      if (ck_sync_ff[1] == ck_sync_ff[2]) ck_line_ff <= ck_sync_ff[2];
      ck_prev_ff <= ck_line_ff;
    end
  end
  wire logic ext_rise = ck_line_ff && !ck_prev_ff;

  // bit-rate sources
  logic [15:0] div_ff;
  logic [3:0]  ext16_ff;
  logic        timer_tick;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      div_ff   <= 16'h0;
      ext16_ff <= 4'h0;
    end else begin
      div_ff   <= (div_ff == 16'(DIV - 1)) ? 16'h0 : div_ff + 16'h1;
      if (ext_rise) ext16_ff <= ext16_ff + 4'h1;
    end
  end
  assign timer_tick = (div_ff == 16'h0);

  // registers
  logic [7:0] clk_src_ff;
  logic       wr_cs, wr_cmd, wr_tx, rd_rx;
  logic [1:0] rx_cmd, tx_cmd;
  logic [2:0] gen_cmd;
  assign wr_cs   = wr && addr == ADDR_CLOCK_SOURCE;
  assign wr_cmd  = wr && addr == ADDR_COMMAND;
  assign wr_tx   = wr && addr == ADDR_TX_DATA;
  assign rd_rx   = rd && addr == ADDR_RX_DATA;
  assign rx_cmd  = wr_cmd ? wdata[RXC_LSB +: 2] : DIR_NONE;
  assign tx_cmd  = wr_cmd ? wdata[TXC_LSB +: 2] : DIR_NONE;
  assign gen_cmd = wr_cmd ? wdata[GEN_LSB +: 3] : GC_NONE;

  always_ff @(posedge ref_clk) begin
    if (!nrst) clk_src_ff <= CS_RESET;
    else if (wr_cs) clk_src_ff <= wdata;
  end
  wire logic rx_tick = tick_of(clk_src_ff[7:4], timer_tick, ext_rise, ext16_ff);
  wire logic tx_tick = tick_of(clk_src_ff[3:0], timer_tick, ext_rise, ext16_ff);

  always_ff @(posedge ref_clk) begin
    if (!nrst) mode_ptr_first <= 1'b1;
    else if (gen_cmd == GC_PTR_RST) mode_ptr_first <= 1'b1;
    else if ((wr || rd) && addr == ADDR_MODE) mode_ptr_first <= 1'b0;
  end

  // transmitter
  usc_tx_type  tx_st_ff;
  logic [7:0]  hold_ff, shift_ff;
  logic        hold_full_ff, tx_free_ff, tx_idle_ff, brk_req_ff;
  logic [3:0]  tx_bit_ff;
  logic        tx_load;
  // a held character goes out before a pending break, else the break would wait forever
  assign tx_load = tx_tick && tx_st_ff == TX_IDLE && hold_full_ff && tx_enabled;

  always_ff @(posedge ref_clk) begin
    if (!nrst) tx_enabled <= 1'b0;
    else if (gen_cmd == GC_TX_RST) tx_enabled <= 1'b0;
    else if (tx_cmd == DIR_ENABLE) tx_enabled <= 1'b1;
    else if (tx_cmd == DIR_DISABLE) tx_enabled <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_free_ff  <= 1'b0;
      tx_idle_ff  <= 1'b0;
    end else if (gen_cmd == GC_TX_RST || tx_cmd == DIR_DISABLE) begin
      tx_free_ff <= 1'b0;
      tx_idle_ff <= 1'b0;
    end else if (tx_cmd == DIR_ENABLE && !tx_enabled) begin
      tx_free_ff  <= 1'b1;
      tx_idle_ff  <= 1'b1;
    end else if (tx_enabled) begin
      if (tx_load) tx_free_ff <= 1'b1;
      else if (wr_tx && tx_free_ff) tx_free_ff <= 1'b0;
      if (tx_load || (wr_tx && tx_free_ff)) tx_idle_ff <= 1'b0;
      else if (tx_st_ff == TX_SHIFT && tx_tick && tx_bit_ff == 4'h9 && !hold_full_ff)
        tx_idle_ff <= 1'b1;
    end
  end

  // holding register only accepts while enabled and free
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_ff      <= 8'h0;
      hold_full_ff <= 1'b0;
    end else if (gen_cmd == GC_TX_RST) begin
      hold_full_ff <= 1'b0;
    end else if (wr_tx && tx_enabled && tx_free_ff) begin
      hold_ff      <= wdata;
      hold_full_ff <= 1'b1;
    end else if (tx_load) begin
      hold_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) brk_req_ff <= 1'b0;
    else if (gen_cmd == GC_TX_RST) brk_req_ff <= 1'b0;
    else if (gen_cmd == GC_BRK_START && tx_enabled) brk_req_ff <= 1'b1;
    else if (gen_cmd == GC_BRK_STOP) brk_req_ff <= 1'b0;
  end

  // 8 data bits, one stop bit; break waits for pending characters
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_st_ff  <= TX_IDLE;
      shift_ff  <= 8'h0;
      tx_bit_ff <= 4'h0;
      txd       <= 1'b1;
    end else if (gen_cmd == GC_TX_RST) begin
      tx_st_ff <= TX_IDLE;
      txd      <= 1'b1;
    end else if (tx_tick) begin
      case (tx_st_ff)
        TX_IDLE: begin
          if (tx_load) begin
            shift_ff  <= hold_ff;
            tx_bit_ff <= 4'h0;
            txd       <= 1'b0;
            tx_st_ff  <= TX_SHIFT;
          end else if (brk_req_ff && !hold_full_ff) begin
            txd      <= 1'b0;
            tx_st_ff <= TX_BREAK;
          end else begin
            txd <= 1'b1;
          end
        end
        TX_SHIFT: begin
          tx_bit_ff <= tx_bit_ff + 4'h1;
          if (tx_bit_ff < 4'h8) begin
            txd      <= shift_ff[0];
            shift_ff <= {1'b0, shift_ff[7:1]};
          end else if (tx_bit_ff == 4'h8) begin
            txd <= 1'b1;
          end else begin
            tx_st_ff <= TX_IDLE;
          end
        end
        TX_BREAK: begin
          if (!brk_req_ff) begin
            txd      <= 1'b1;
            tx_st_ff <= TX_IDLE;
          end else begin
            txd <= 1'b0;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // receiver, sampling once per tick of its selected clock source
  usc_rx_type rx_st_ff;
  logic [7:0] rx_sh_ff;
  logic [3:0] rx_bit_ff;
  logic [8:0] fifo_ff [FIFO_DEPTH];
  logic [1:0] cnt_ff, rptr_ff, wptr_ff;
  logic       push;
  logic [2:0] err_ff;
  logic       ovr_ff, brk_edge_ff, in_brk_ff;
  logic [7:0] rx_word;
  logic       rx_err_frame, rx_is_brk;

  assign rx_is_brk = (rx_sh_ff == 8'h0) && !rx_line_ff;
  assign rx_err_frame = !rx_line_ff;
  wire logic rx_enabled_eff = rx_enabled || loopback_mode || multidrop_mode;
  assign push = rx_tick && rx_st_ff == RX_STOP && rx_enabled_eff;
  wire logic pop = rd_rx && cnt_ff != 2'h0;

  always_ff @(posedge ref_clk) begin
    if (!nrst) rx_enabled <= 1'b0;
    else if (gen_cmd == GC_RX_RST) rx_enabled <= 1'b0;
    else if (rx_cmd == DIR_ENABLE) rx_enabled <= 1'b1;
    else if (rx_cmd == DIR_DISABLE) rx_enabled <= 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_st_ff  <= RX_IDLE;
      rx_sh_ff  <= 8'h0;
      rx_bit_ff <= 4'h0;
    end else if (!rx_enabled_eff || (rx_cmd == DIR_ENABLE && !rx_enabled && !multidrop_mode)) begin
      rx_st_ff <= RX_IDLE;
    end else if (rx_tick) begin
      case (rx_st_ff)
        RX_IDLE: if (!rx_line_ff) begin
          rx_st_ff  <= RX_DATA;
          rx_bit_ff <= 4'h0;
        end
        RX_DATA: begin
          rx_sh_ff  <= {rx_line_ff, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_bit_ff == 4'h7) rx_st_ff <= RX_STOP;
        end
        RX_STOP: rx_st_ff <= RX_IDLE;
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // three-entry fifo, word holds data and framing status
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_ff  <= 2'h0;
      rptr_ff <= 2'h0;
      wptr_ff <= 2'h0;
      for (int i = 0; i < FIFO_DEPTH; i++) fifo_ff[i] <= 9'h0;
    end else if (gen_cmd == GC_RX_RST) begin
      cnt_ff  <= 2'h0;
      rptr_ff <= 2'h0;
      wptr_ff <= 2'h0;
    end else begin
      if (push && cnt_ff != 2'(FIFO_DEPTH)) begin
        fifo_ff[wptr_ff] <= {rx_err_frame, rx_sh_ff};
        wptr_ff <= (wptr_ff == 2'(FIFO_DEPTH - 1)) ? 2'h0 : wptr_ff + 2'h1;
      end
      if (pop) rptr_ff <= (rptr_ff == 2'(FIFO_DEPTH - 1)) ? 2'h0 : rptr_ff + 2'h1;
      cnt_ff <= cnt_ff + 2'(push && cnt_ff != 2'(FIFO_DEPTH)) - 2'(pop);
    end
  end
  assign rx_word = fifo_ff[rptr_ff][7:0];

  // error flags: a new event in the clearing cycle still sets
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      err_ff      <= 3'h0;
      ovr_ff      <= 1'b0;
      brk_edge_ff <= 1'b0;
      in_brk_ff   <= 1'b0;
    end else begin
      if (push) err_ff <= ((gen_cmd == GC_ERR_CLR) ? 3'h0 : err_ff)
                          | {rx_is_brk, rx_err_frame && !rx_is_brk, 1'b0};
      else if (gen_cmd == GC_ERR_CLR) err_ff <= 3'h0;
      ovr_ff <= (push && cnt_ff == 2'(FIFO_DEPTH)) || (ovr_ff && gen_cmd != GC_ERR_CLR);
      in_brk_ff <= push ? rx_is_brk : in_brk_ff;
      brk_edge_ff <= (push && rx_is_brk != in_brk_ff) || (brk_edge_ff && gen_cmd != GC_BRK_CLR);
    end
  end

  // read data, one cycle after the strobe; zero when no read
  always_ff @(posedge ref_clk) begin
    if (!nrst) rdata <= 8'h0;
    else if (rd) begin
      case (addr)
        ADDR_LINE_STATUS: rdata <= {err_ff[2], err_ff[1], err_ff[0], ovr_ff,
                                    tx_idle_ff, tx_free_ff && tx_enabled,
                                    cnt_ff == 2'(FIFO_DEPTH),
                                    cnt_ff != 2'h0};
        ADDR_IRQ_STATUS:  rdata <= {5'h0, brk_edge_ff, cnt_ff != 2'h0, tx_free_ff};
        ADDR_RX_DATA:     rdata <= rx_word;
        default:          rdata <= 8'h0;
      endcase
    end else rdata <= 8'h0;
  end
endmodule : usc_top
`default_nettype wire

// ==== dv/usc_top_sva.sv ====
// port-level checks for the serial status and command block
`timescale 1ns/1ns
`default_nettype none
module usc_top_sva
  import usc_pkg::*;
#(
  parameter int DIV = BAUD_DIV_DEFAULT
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // line and side signals
  input wire logic       txd,
  input wire logic       loopback_mode,
  input wire logic       multidrop_mode,
  input wire logic       mode_ptr_first,
  input wire logic       rx_enabled,
  input wire logic       tx_enabled
);
  // two bit times plus slack for the line register
  localparam int BRK_MAX = 2 * DIV + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_cmd;
    wr && addr == ADDR_COMMAND;
  endsequence
  sequence s_stat_rd;
    rd && addr == ADDR_LINE_STATUS;
  endsequence
  chk_rdata_quiet:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside read slot");
  chk_tx_on:
    assert property (s_cmd ##0 (wdata[3:2] == DIR_ENABLE && wdata[6:4] != GC_TX_RST) |=> tx_enabled)
    else $error("transmitter not enabled");
  chk_tx_rst:
    assert property (s_cmd ##0 wdata[6:4] == GC_TX_RST |=> !tx_enabled) else $error("tx reset ignored");
  chk_rx_on:
    assert property (s_cmd ##0 (wdata[1:0] == DIR_ENABLE && wdata[6:4] != GC_RX_RST) |=> rx_enabled)
    else $error("receiver not enabled");
  chk_rx_rst:
    assert property (s_cmd ##0 wdata[6:4] == GC_RX_RST |=> !rx_enabled) else $error("rx reset ignored");
  chk_rx_off:
    assert property (s_cmd ##0 (wdata[1:0] == DIR_DISABLE && !loopback_mode && !multidrop_mode)
      |=> !rx_enabled) else $error("receiver disable ignored");
  chk_ptr_first:
    assert property (s_cmd ##0 wdata[6:4] == GC_PTR_RST |=> mode_ptr_first) else $error("mode pointer not reset");
  chk_free_off:
    assert property (s_stat_rd ##0 (!tx_enabled && !$past(tx_enabled)) |=> !rdata[ST_TX_FREE])
    else $error("free flag set while transmitter off");
  chk_full_wait:
    assert property (s_stat_rd |=> !rdata[ST_RX_FULL] || rdata[ST_RX_WAIT]) else $error("full without waiting");
  chk_brk_stop:
    assert property (s_cmd ##0 (wdata[6:4] == GC_BRK_STOP && tx_enabled) |-> ##[1:BRK_MAX] txd)
    else $error("line not back to mark after stop break");
endmodule : usc_top_sva
bind usc_top usc_top_sva #(.DIV(DIV)) u_sva (.ref_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .txd,
  .loopback_mode, .multidrop_mode, .mode_ptr_first, .rx_enabled, .tx_enabled);
`default_nettype wire

// ==== dv/usc_line_model.sv ====
// remote serial device: sends frames on rxd, collects frames from txd
`timescale 1ns/1ns
`default_nettype none
module usc_line_model (
  // clock and bit length in clock cycles
  input  wire logic       clk,
  input  wire logic [7:0] bit_cyc,
  // serial lines
  input  wire logic       txd,
  output logic            rxd
);
  logic [7:0] got[$];
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // lsb first, one start and one stop bit
  task automatic send(input logic [7:0] b);
    rxd <= 1'b0;
    hold(bit_cyc);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      hold(bit_cyc);
    end
    rxd <= 1'b1;
    hold(bit_cyc);
  endtask : send
  task automatic brk(input int n);
    rxd <= 1'b0;
    hold(n);
    rxd <= 1'b1;
    hold(n);
  endtask : brk
  initial begin
    logic [7:0] b;
    rxd = 1'b1;
    forever begin
      @(negedge txd);
      hold(bit_cyc + bit_cyc / 2);
      for (int i = 0; i < 8; i++) begin
        b[i] = txd;
        hold(bit_cyc);
      end
      // a frame without its stop bit (a break) is dropped
      if (txd) got.push_back(b);
    end
  end
endmodule : usc_line_model
`default_nettype wire

// ==== dv/usc_top_tb.sv ====
// self-checking bench for the status, clock select and command block
`timescale 1ns/1ns
`default_nettype none
module usc_top_tb;
  import usc_pkg::*;
  localparam int DIV = 4;
  logic       ref_clk, nrst, wr, rd, ext_clk, rxd, txd;
  logic       mode_ptr_first, rx_enabled, tx_enabled;
  logic       loop_m, mdrop_m;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, bit_cyc, d;
  int         error_cnt, n_checks;
  usc_top #(.DIV(DIV)) dut (.ref_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .rxd, .ext_clk, .txd,
    .loopback_mode(loop_m), .multidrop_mode(mdrop_m), .mode_ptr_first, .rx_enabled, .tx_enabled);
  usc_line_model u_far (.clk(ref_clk), .bit_cyc, .txd, .rxd);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // external bit clock, 12 cycles a period
  always #120 ext_clk = ~ext_clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd <= 1'b1; addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic poll(input int b);
    d = 8'h00;
    for (int i = 0; i < 400 && d[b] !== 1'b1; i++) rd_reg(ADDR_LINE_STATUS, d);
    if (d[b] !== 1'b1) begin error_cnt++; close_out(); end
  endtask : poll
  task automatic wait_got(input int n);
    for (int i = 0; i < 5000 && u_far.got.size() < n; i++) @(posedge ref_clk);
    if (u_far.got.size() < n) begin error_cnt++; close_out(); end
  endtask : wait_got
  task automatic wait_txd(input logic v, input int lim);
    for (int i = 0; i < lim && txd !== v; i++) @(posedge ref_clk);
    check("txd", txd, v);
  endtask : wait_txd
  task automatic t_reset;
    rd_reg(ADDR_LINE_STATUS, d);
    check("status", d, 8'h00);
    rd_reg(ADDR_MODE, d);
    check("ptr moved", mode_ptr_first, 1'b0);
    wr_reg(ADDR_COMMAND, 8'h10);
    check("ptr", mode_ptr_first, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_tx;
    wr_reg(ADDR_COMMAND, 8'h05);
    check("rx on", rx_enabled, 1'b1);
    rd_reg(ADDR_LINE_STATUS, d);
    check("status", d, 8'h0c);
    rd_reg(ADDR_IRQ_STATUS, d);
    check("irq free", d & 8'h01, 8'h01);
    wr_reg(ADDR_TX_DATA, 8'ha5);
    poll(ST_TX_FREE);
    check("idle busy", d[ST_TX_IDLE], 1'b0);
    wr_reg(ADDR_TX_DATA, 8'h3c);
    wait_got(2);
    check("frame0", u_far.got.pop_front(), 8'ha5);
    check("frame1", u_far.got.pop_front(), 8'h3c);
    poll(ST_TX_IDLE);
    check("status", d & 8'h0c, 8'h0c);
    $display("transmit test done");
  endtask : t_tx
  task automatic t_tx_off;
    wr_reg(ADDR_COMMAND, 8'h08);
    rd_reg(ADDR_LINE_STATUS, d);
    check("status", d & 8'h0c, 8'h00);
    wr_reg(ADDR_TX_DATA, 8'h77);
    wr_reg(ADDR_COMMAND, 8'h04);
    repeat (12 * DIV) @(posedge ref_clk);
    check("frames", 8'(u_far.got.size()), 8'h00);
    wr_reg(ADDR_COMMAND, 8'h30);
    rd_reg(ADDR_LINE_STATUS, d);
    check("status", d & 8'h0c, 8'h00);
    $display("transmit disable test done");
  endtask : t_tx_off
  task automatic t_clk_sel;
    // each direction is reset before its clock changes
    wr_reg(ADDR_CLOCK_SOURCE, {CS_TIMER, CS_EXT1});
    wr_reg(ADDR_COMMAND, 8'h04);
    bit_cyc = 8'd12;
    wr_reg(ADDR_TX_DATA, 8'h5a);
    wait_got(1);
    check("x1 frame", u_far.got.pop_front(), 8'h5a);
    wr_reg(ADDR_COMMAND, 8'h30);
    wr_reg(ADDR_COMMAND, 8'h20);
    wr_reg(ADDR_CLOCK_SOURCE, {CS_EXT16, CS_TIMER});
    wr_reg(ADDR_COMMAND, 8'h01);
    bit_cyc = 8'd192;
    u_far.send(8'hc3);
    poll(ST_RX_WAIT);
    rd_reg(ADDR_RX_DATA, d);
    check("x16 char", d, 8'hc3);
    wr_reg(ADDR_COMMAND, 8'h20);
    wr_reg(ADDR_CLOCK_SOURCE, CS_RESET);
    bit_cyc = 8'(DIV);
    $display("clock select test done");
  endtask : t_clk_sel
  task automatic t_rx;
    wr_reg(ADDR_COMMAND, 8'h01);
    for (int i = 1; i < 4; i++) u_far.send(8'(8'h11 * i));
    poll(ST_RX_FULL);
    check("full", d & 8'h03, 8'h03);
    for (int i = 1; i < 4; i++) begin
      rd_reg(ADDR_RX_DATA, d);
      check("char", d, 8'(8'h11 * i));
      rd_reg(ADDR_LINE_STATUS, d);
      check("wait", d & 8'h03, {7'h00, i < 3});
    end
    u_far.send(8'h44);
    poll(ST_RX_WAIT);
    wr_reg(ADDR_COMMAND, 8'h20);
    rd_reg(ADDR_LINE_STATUS, d);
    check("rx reset", {5'h00, rx_enabled, d[1:0]}, 8'h00);
    // loopback first, then multidrop: the disable command must not stop reception
    for (int m = 0; m < 2; m++) begin
      loop_m  <= (m == 0);
      mdrop_m <= (m == 1);
      wr_reg(ADDR_COMMAND, 8'h01);
      wr_reg(ADDR_COMMAND, 8'h02);
      check("rx off", {7'h00, rx_enabled}, 8'h00);
      u_far.send(8'(8'h5e + m));
      poll(ST_RX_WAIT);
      rd_reg(ADDR_RX_DATA, d);
      check("mode char", d, 8'(8'h5e + m));
      wr_reg(ADDR_COMMAND, 8'h20);
    end
    loop_m  <= 1'b0;
    mdrop_m <= 1'b0;
    $display("receive test done");
  endtask : t_rx
  task automatic t_break;
    wr_reg(ADDR_COMMAND, 8'h60);
    repeat (3 * DIV) @(posedge ref_clk);
    check("no break", txd, 1'b1);
    wr_reg(ADDR_COMMAND, 8'h04);
    wr_reg(ADDR_COMMAND, 8'h60);
    wait_txd(1'b0, 2 * DIV + 6);
    repeat (4 * DIV) @(posedge ref_clk);
    check("held", txd, 1'b0);
    wr_reg(ADDR_COMMAND, 8'h70);
    wait_txd(1'b1, 2 * DIV + 4);
    wr_reg(ADDR_COMMAND, 8'h01);
    u_far.brk(14 * DIV);
    rd_reg(ADDR_IRQ_STATUS, d);
    check("edge", d[IRQ_BRK_EDGE], 1'b1);
    rd_reg(ADDR_LINE_STATUS, d);
    check("break set", d[ST_BREAK], 1'b1);
    wr_reg(ADDR_COMMAND, 8'h40);
    rd_reg(ADDR_LINE_STATUS, d);
    check("errors", d & 8'hf0, 8'h00);
    wr_reg(ADDR_COMMAND, 8'h50);
    rd_reg(ADDR_IRQ_STATUS, d);
    check("edge clr", d[IRQ_BRK_EDGE], 1'b0);
    $display("break test done");
  endtask : t_break
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; ext_clk = 1'b0;
    loop_m = 1'b0;
    mdrop_m = 1'b0;
    addr = 2'h0; wdata = 8'h00; bit_cyc = 8'(DIV);
    error_cnt = 0; n_checks = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_tx();
    t_tx_off();
    t_clk_sel();
    t_rx();
    t_break();
    close_out();
  end
endmodule : usc_top_tb
`default_nettype wire
